// file: nad_datapath.sv
module nad_datapath (
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     srst_i,
  // Operation from the sequencer
  input  wire logic                     op_valid_i,
  input  wire nad_pkg::nad_op_s         op_i,
  // Operand nibble read from data memory for this operation
  input  wire logic [3:0]               mem_rdata_i,
  // Data memory write port
  output      logic                     mem_we_o,
  output      logic [7:0]               mem_addr_o,
  output      logic [3:0]               mem_wdata_o,
  // Core state
  output      logic [3:0]               acc_o,
  output      logic                     carry_o,
  output      logic                     zero_o,
  output      nad_pkg::nad_sfr_t        sfr_o
);

  // ***************************************************************
  // State
  // ***************************************************************
  nad_pkg::nad_state_s st_r;
  nad_pkg::nad_state_s st_nxt;

  logic [3:0] a;
  logic [3:0] m;
  logic       c;
  logic [4:0] sum5;
  logic [7:0] win_addr;
  logic [3:0] bit_mask;

  // ***************************************************************
  // Next-state logic
  // ***************************************************************
  always_comb begin
    a        = st_r.accumulator_nibble;
    m        = mem_rdata_i;
    c        = st_r.carry;
    sum5     = 5'h00;
    win_addr = {nad_pkg::NAD_WIN_BASE, op_i.win_off};
    bit_mask = 4'h1 << op_i.bit_sel;
    st_nxt   = st_r;
    st_nxt.mem_we = 1'h0;
    if (op_valid_i) begin
      case (op_i.op)
        nad_pkg::OP_ADD_MEM_CARRY: begin
          sum5 = {1'h0, a} + {1'h0, m} + {4'h0, c};
          st_nxt.accumulator_nibble = sum5[3:0];
          st_nxt.carry = sum5[4];
          st_nxt.zero  = (sum5[3:0] == 4'h0);
        end
        nad_pkg::OP_INCREMENT_MEM: begin
          sum5 = {1'h0, m} + 5'h01;
          st_nxt.mem_we    = 1'h1;
          st_nxt.mem_addr  = op_i.mem_addr;
          st_nxt.mem_wdata = sum5[3:0];
          st_nxt.carry = sum5[4];
          st_nxt.zero  = (sum5[3:0] == 4'h0);
        end
        nad_pkg::OP_DECREMENT_MEM: begin
          // Adding 0xF: carry out means no borrow
          sum5 = {1'h0, m} + 5'h0F;
          st_nxt.mem_we    = 1'h1;
          st_nxt.mem_addr  = op_i.mem_addr;
          st_nxt.mem_wdata = sum5[3:0];
          st_nxt.carry = sum5[4];
          st_nxt.zero  = (sum5[3:0] == 4'h0);
        end
        nad_pkg::OP_XOR_MEM: begin
          st_nxt.accumulator_nibble = a ^ m;
          st_nxt.zero = ((a ^ m) == 4'h0);
        end
        nad_pkg::OP_ROTATE_MEM_RIGHT: begin
          st_nxt.mem_we    = 1'h1;
          st_nxt.mem_addr  = op_i.mem_addr;
          st_nxt.mem_wdata = {c, m[3:1]};
          st_nxt.carry     = m[0];
        end
        nad_pkg::OP_ROTATE_MEM_LEFT: begin
          st_nxt.mem_we    = 1'h1;
          st_nxt.mem_addr  = op_i.mem_addr;
          st_nxt.mem_wdata = {m[2:0], c};
          st_nxt.carry     = m[3];
        end
        nad_pkg::OP_STORE_ACCUMULATOR: begin
          st_nxt.mem_we    = 1'h1;
          st_nxt.mem_addr  = op_i.mem_addr;
          st_nxt.mem_wdata = a;
        end
        nad_pkg::OP_LOAD_ACCUMULATOR: begin
          st_nxt.accumulator_nibble = m;
          st_nxt.zero = (m == 4'h0);
        end
        nad_pkg::OP_AND_MEM: begin
          st_nxt.accumulator_nibble = a & m;
          st_nxt.zero = ((a & m) == 4'h0);
        end
        nad_pkg::OP_SUB_MEM_BORROW: begin
          sum5 = {1'h0, a} + {1'h0, ~m} + {4'h0, c};
          st_nxt.accumulator_nibble = sum5[3:0];
          st_nxt.carry = sum5[4];
        end
        nad_pkg::OP_OR_MEM: begin
          st_nxt.accumulator_nibble = a | m;
        end
        nad_pkg::OP_BIT_CLEAR: begin
          st_nxt.mem_we    = 1'h1;
          st_nxt.mem_addr  = win_addr;
          st_nxt.mem_wdata = m & ~bit_mask;
        end
        nad_pkg::OP_BIT_SET: begin
          st_nxt.mem_we    = 1'h1;
          st_nxt.mem_addr  = win_addr;
          st_nxt.mem_wdata = m | bit_mask;
        end
        nad_pkg::OP_FUNC_REG_TO_MEM: begin
          st_nxt.mem_we    = 1'h1;
          st_nxt.mem_addr  = win_addr;
          st_nxt.mem_wdata = st_r.system_function_reg[op_i.sfr_sel];
        end
        nad_pkg::OP_MEM_TO_FUNC_REG: begin
          st_nxt.system_function_reg[op_i.sfr_sel] = m;
        end
        nad_pkg::OP_LITERAL_TO_FUNC_REG: begin
          st_nxt.system_function_reg[op_i.sfr_sel] = op_i.literal;
        end
        nad_pkg::OP_LITERAL_TO_ACCUMULATOR: begin
          st_nxt.accumulator_nibble = op_i.literal;
        end
        nad_pkg::OP_SUB_LITERAL_BORROW: begin
          sum5 = {1'h0, a} + {1'h0, ~op_i.literal} + {4'h0, c};
          st_nxt.accumulator_nibble = sum5[3:0];
          st_nxt.carry = sum5[4];
          st_nxt.zero  = (sum5[3:0] == 4'h0);
        end
        nad_pkg::OP_ADD_LITERAL_CARRY: begin
          sum5 = {1'h0, a} + {1'h0, op_i.literal} + {4'h0, c};
          st_nxt.accumulator_nibble = sum5[3:0];
          st_nxt.carry = sum5[4];
          st_nxt.zero  = (sum5[3:0] == 4'h0);
        end
        nad_pkg::OP_AND_LITERAL: begin
          st_nxt.accumulator_nibble = a & op_i.literal;
          st_nxt.zero = ((a & op_i.literal) == 4'h0);
        end
        nad_pkg::OP_OR_LITERAL: begin
          st_nxt.accumulator_nibble = a | op_i.literal;
        end
        nad_pkg::OP_XOR_LITERAL: begin
          st_nxt.accumulator_nibble = a ^ op_i.literal;
        end
        nad_pkg::OP_INCREMENT_ACCUMULATOR: begin
          sum5 = {1'h0, a} + 5'h01;
          st_nxt.accumulator_nibble = sum5[3:0];
          st_nxt.carry = sum5[4];
          st_nxt.zero  = (sum5[3:0] == 4'h0);
        end
        nad_pkg::OP_DECREMENT_ACCUMULATOR: begin
          sum5 = {1'h0, a} + 5'h0F;
          st_nxt.accumulator_nibble = sum5[3:0];
          st_nxt.carry = sum5[4];
          st_nxt.zero  = (sum5[3:0] == 4'h0);
        end
        nad_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY: begin
          st_nxt.accumulator_nibble = {c, a[3:1]};
          st_nxt.carry = a[0];
          st_nxt.zero  = ({c, a[3:1]} == 4'h0);
        end
        nad_pkg::OP_ROTATE_LEFT_THROUGH_CARRY: begin
          st_nxt.accumulator_nibble = {a[2:0], c};
          st_nxt.carry = a[3];
          st_nxt.zero  = ({a[2:0], c} == 4'h0);
        end
        nad_pkg::OP_ROTATE_ACCUMULATOR_RIGHT: begin
          st_nxt.accumulator_nibble = {a[0], a[3:1]};
          st_nxt.zero = ({a[0], a[3:1]} == 4'h0);
        end
        default: begin
          st_nxt.mem_we = 1'h0;
        end
      endcase
    end
  end

  // ***************************************************************
  // State register
  // ***************************************************************
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_r.accumulator_nibble  <= nad_pkg::NAD_ACC_RST;
      st_r.carry               <= nad_pkg::NAD_FLAG_RST;
      st_r.zero                <= nad_pkg::NAD_FLAG_RST;
      st_r.system_function_reg <= {nad_pkg::NAD_SFR_N{nad_pkg::NAD_SFR_RST}};
      st_r.mem_we              <= 1'h0;
      st_r.mem_addr            <= nad_pkg::NAD_ADDR_RST;
      st_r.mem_wdata           <= nad_pkg::NAD_ACC_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign mem_we_o    = st_r.mem_we;
  assign mem_addr_o  = st_r.mem_addr;
  assign mem_wdata_o = st_r.mem_wdata;
  assign acc_o       = st_r.accumulator_nibble;
  assign carry_o     = st_r.carry;
  assign zero_o      = st_r.zero;
  assign sfr_o       = st_r.system_function_reg;

  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  sequence s_issue(nad_pkg::nad_op_e o);
    op_valid_i && op_i.op == o;
  endsequence

  a_add_mem_sum: assert property (s_issue(nad_pkg::OP_ADD_MEM_CARRY) |=>
    {carry_o, acc_o} == $past({1'h0, acc_o}) + $past({1'h0, mem_rdata_i}) + $past({4'h0, carry_o}))
    else $error("add with carry result wrong");

  a_inc_mem_wb: assert property (s_issue(nad_pkg::OP_INCREMENT_MEM) |=>
    mem_we_o && mem_addr_o == $past(op_i.mem_addr)
    && {carry_o, mem_wdata_o} == $past({1'h0, mem_rdata_i}) + 5'h01)
    else $error("memory increment wrong");

  a_dec_mem_wrap: assert property (s_issue(nad_pkg::OP_DECREMENT_MEM) |=>
    mem_we_o && mem_wdata_o == $past(mem_rdata_i) - 4'h1
    && carry_o == ($past(mem_rdata_i) != 4'h0))
    else $error("memory decrement wrong");

  a_xor_mem_acc: assert property (s_issue(nad_pkg::OP_XOR_MEM) |=>
    acc_o == ($past(acc_o) ^ $past(mem_rdata_i)) && $stable(carry_o))
    else $error("xor with memory wrong");

  a_rot_mem_right: assert property (s_issue(nad_pkg::OP_ROTATE_MEM_RIGHT) |=>
    {mem_wdata_o, carry_o} == $past({carry_o, mem_rdata_i}) && mem_we_o)
    else $error("memory right rotate wrong");

  a_rot_mem_left: assert property (s_issue(nad_pkg::OP_ROTATE_MEM_LEFT) |=>
    {carry_o, mem_wdata_o} == $past({mem_rdata_i, carry_o}) && mem_we_o)
    else $error("memory left rotate wrong");

  a_store_no_flag: assert property (s_issue(nad_pkg::OP_STORE_ACCUMULATOR) |=>
    mem_we_o && mem_wdata_o == $past(acc_o) && $stable(carry_o) && $stable(zero_o))
    else $error("accumulator store wrong");

  a_load_acc_zero: assert property (s_issue(nad_pkg::OP_LOAD_ACCUMULATOR) |=>
    acc_o == $past(mem_rdata_i) && zero_o == ($past(mem_rdata_i) == 4'h0))
    else $error("accumulator load wrong");

  a_and_mem_acc: assert property (s_issue(nad_pkg::OP_AND_MEM) |=>
    acc_o == ($past(acc_o) & $past(mem_rdata_i)) && !mem_we_o)
    else $error("and with memory wrong");

  a_sub_mem_borrow: assert property (s_issue(nad_pkg::OP_SUB_MEM_BORROW) |=>
    acc_o == $past(acc_o) - $past(mem_rdata_i) - {3'h0, ~$past(carry_o)}
    && carry_o == ({1'h0, $past(acc_o)} >= {1'h0, $past(mem_rdata_i)} + {4'h0, ~$past(carry_o)})
    && $stable(zero_o))
    else $error("subtract with borrow wrong");

  a_or_mem_flags: assert property (s_issue(nad_pkg::OP_OR_MEM) |=>
    acc_o == ($past(acc_o) | $past(mem_rdata_i)) && $stable(carry_o) && $stable(zero_o))
    else $error("or with memory wrong");

  a_bit_clear_win: assert property (s_issue(nad_pkg::OP_BIT_CLEAR) |=>
    mem_we_o && mem_addr_o[7:5] == nad_pkg::NAD_WIN_BASE
    && mem_wdata_o[$past(op_i.bit_sel)] == 1'h0 && $stable(carry_o))
    else $error("bit clear wrong");

  a_bit_set_win: assert property (s_issue(nad_pkg::OP_BIT_SET) |=>
    mem_we_o && mem_addr_o[4:0] == $past(op_i.win_off)
    && mem_wdata_o == ($past(mem_rdata_i) | (4'h1 << $past(op_i.bit_sel))))
    else $error("bit set wrong");

  a_sfr_to_mem: assert property (s_issue(nad_pkg::OP_FUNC_REG_TO_MEM) |=>
    mem_we_o && mem_wdata_o == $past(sfr_o[op_i.sfr_sel]) && $stable(zero_o))
    else $error("function register copy out wrong");

  a_mem_to_sfr: assert property (s_issue(nad_pkg::OP_MEM_TO_FUNC_REG) |=>
    sfr_o[$past(op_i.sfr_sel)] == $past(mem_rdata_i) && !mem_we_o)
    else $error("function register copy in wrong");

  a_lit_to_sfr: assert property (s_issue(nad_pkg::OP_LITERAL_TO_FUNC_REG) |=>
    sfr_o[$past(op_i.sfr_sel)] == $past(op_i.literal) && $stable(carry_o))
    else $error("function register literal wrong");

  a_lit_acc_keep: assert property (s_issue(nad_pkg::OP_LITERAL_TO_ACCUMULATOR) |=>
    acc_o == $past(op_i.literal) && $stable(zero_o) && $stable(carry_o))
    else $error("literal load wrong");

  a_sub_lit_flags: assert property (s_issue(nad_pkg::OP_SUB_LITERAL_BORROW) |=>
    acc_o == $past(acc_o) - $past(op_i.literal) - {3'h0, ~$past(carry_o)}
    && zero_o == (acc_o == 4'h0))
    else $error("literal subtract wrong");

  a_add_lit_sum: assert property (s_issue(nad_pkg::OP_ADD_LITERAL_CARRY) |=>
    {carry_o, acc_o} == $past({1'h0, acc_o}) + $past({1'h0, op_i.literal}) + $past({4'h0, carry_o}))
    else $error("literal add wrong");

  a_or_lit_noz: assert property (s_issue(nad_pkg::OP_OR_LITERAL) ##1 s_issue(nad_pkg::OP_XOR_LITERAL)
    |=> $past(zero_o, 2) == zero_o)
    else $error("literal or/xor touched zero");

  a_dec_acc_wrap: assert property (s_issue(nad_pkg::OP_DECREMENT_ACCUMULATOR) |=>
    acc_o == $past(acc_o) - 4'h1 && carry_o == ($past(acc_o) != 4'h0))
    else $error("accumulator decrement wrong");

  a_rot_acc_carry: assert property (s_issue(nad_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY) |=>
    {acc_o, carry_o} == $past({carry_o, acc_o}))
    else $error("accumulator right rotate through carry wrong");

  a_rot_acc_plain: assert property (s_issue(nad_pkg::OP_ROTATE_ACCUMULATOR_RIGHT) |=>
    acc_o == {$past(acc_o[0]), $past(acc_o[3:1])} && $stable(carry_o))
    else $error("accumulator plain rotate wrong");

  a_zero_tracks: assert property (op_valid_i && (op_i.op == nad_pkg::OP_INCREMENT_ACCUMULATOR
    || op_i.op == nad_pkg::OP_ROTATE_LEFT_THROUGH_CARRY) |=> zero_o == (acc_o == 4'h0))
    else $error("zero flag does not follow result");

  c_add_carry_out: cover property (s_issue(nad_pkg::OP_ADD_MEM_CARRY) ##1 carry_o);
  c_sfr_round_trip: cover property (s_issue(nad_pkg::OP_LITERAL_TO_FUNC_REG)
    ##1 s_issue(nad_pkg::OP_FUNC_REG_TO_MEM) ##1 mem_we_o);
  c_bit_set: cover property (s_issue(nad_pkg::OP_BIT_SET) ##1 mem_we_o);
  c_dec_wrap: cover property (s_issue(nad_pkg::OP_DECREMENT_ACCUMULATOR) ##1 acc_o == 4'hF);

endmodule

// file: nad_mem_model.sv
// ***************************************************************
// Sequencer side: operand fetch and data memory
// ***************************************************************
module nad_mem_model (
  // Clock
  input  wire logic             clk_i,
  // Operation as issued to the datapath
  input  wire logic             op_valid_i,
  input  wire nad_pkg::nad_op_s op_i,
  // Write port driven by the datapath
  input  wire logic             mem_we_i,
  input  wire logic [7:0]       mem_addr_i,
  input  wire logic [3:0]       mem_wdata_i,
  // Operand nibble for the issued operation
  output      logic [3:0]       mem_rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] mem [256];
  logic [7:0] rd_addr;
  logic       noise_r = 1'b0;

  always_comb begin
    if (op_i.op inside {nad_pkg::OP_BIT_CLEAR, nad_pkg::OP_BIT_SET, nad_pkg::OP_FUNC_REG_TO_MEM,
                        nad_pkg::OP_MEM_TO_FUNC_REG}) begin
      rd_addr = {nad_pkg::NAD_WIN_BASE, op_i.win_off};
    end else begin
      rd_addr = op_i.mem_addr;
    end
  end

  // Forward a write still in flight; toggle the bus when nothing is fetched
  assign mem_rdata_o = !op_valid_i ? {2{noise_r, ~noise_r}} :
                       (mem_we_i && mem_addr_i == rd_addr) ? mem_wdata_i : mem[rd_addr];

  always @(posedge clk_i) begin
    noise_r <= ~noise_r;
    if (mem_we_i) begin
      mem[mem_addr_i] <= mem_wdata_i;
    end
  end
endmodule

// file: nad_pkg.sv
package nad_pkg;

  // ***************************************************************
  // Widths and window layout
  // ***************************************************************
  localparam int          NAD_NIB_W    = 4;
  localparam int          NAD_ADDR_W   = 8;
  localparam int          NAD_WIN_W    = 5;
  localparam int          NAD_BIT_W    = 2;
  localparam int          NAD_SEL_W    = 3;
  localparam int          NAD_SFR_N    = 8;
  // Upper address bits of the 32-nibble general window (0x20..0x3F)
  localparam logic [2:0]  NAD_WIN_BASE = 3'h1;

  // ***************************************************************
  // Reset values
  // ***************************************************************
  localparam logic [3:0]  NAD_ACC_RST  = 4'h0;
  localparam logic        NAD_FLAG_RST = 1'h0;
  localparam logic [3:0]  NAD_SFR_RST  = 4'h0;
  localparam logic [7:0]  NAD_ADDR_RST = 8'h00;

  // ***************************************************************
  // Operations issued by the sequencer
  // ***************************************************************
  typedef enum logic [4:0] {
    OP_NOP,
    OP_ADD_MEM_CARRY,
    OP_INCREMENT_MEM,
    OP_DECREMENT_MEM,
    OP_XOR_MEM,
    OP_ROTATE_MEM_RIGHT,
    OP_ROTATE_MEM_LEFT,
    OP_STORE_ACCUMULATOR,
    OP_LOAD_ACCUMULATOR,
    OP_AND_MEM,
    OP_SUB_MEM_BORROW,
    OP_OR_MEM,
    OP_BIT_CLEAR,
    OP_BIT_SET,
    OP_FUNC_REG_TO_MEM,
    OP_MEM_TO_FUNC_REG,
    OP_LITERAL_TO_FUNC_REG,
    OP_LITERAL_TO_ACCUMULATOR,
    OP_SUB_LITERAL_BORROW,
    OP_ADD_LITERAL_CARRY,
    OP_AND_LITERAL,
    OP_OR_LITERAL,
    OP_XOR_LITERAL,
    OP_INCREMENT_ACCUMULATOR,
    OP_DECREMENT_ACCUMULATOR,
    OP_ROTATE_RIGHT_THROUGH_CARRY,
    OP_ROTATE_LEFT_THROUGH_CARRY,
    OP_ROTATE_ACCUMULATOR_RIGHT
  } nad_op_e;

  typedef struct packed {
    nad_op_e                 op;
    logic [NAD_ADDR_W-1:0]   mem_addr;
    logic [NAD_WIN_W-1:0]    win_off;
    logic [NAD_BIT_W-1:0]    bit_sel;
    logic [NAD_SEL_W-1:0]    sfr_sel;
    logic [NAD_NIB_W-1:0]    literal;
  } nad_op_s;

  typedef logic [NAD_SFR_N-1:0][NAD_NIB_W-1:0] nad_sfr_t;

  typedef struct packed {
    logic [NAD_NIB_W-1:0]    accumulator_nibble;
    logic                    carry;
    logic                    zero;
    nad_sfr_t                system_function_reg;
    logic                    mem_we;
    logic [NAD_ADDR_W-1:0]   mem_addr;
    logic [NAD_NIB_W-1:0]    mem_wdata;
  } nad_state_s;

endpackage

// file: tb_nibble_alu_datapath.sv
module tb_nibble_alu_datapath;
  timeunit 1ns;
  timeprecision 1ps;

  // ***************************************************************
  // Signals and instances
  // ***************************************************************
  logic              clk_i      = 1'b0;
  logic              srst_i     = 1'b1;
  logic              op_valid_i = 1'b0;
  nad_pkg::nad_op_s  op_i       = '0;
  logic [3:0]        mem_rdata;
  logic              mem_we_o;
  logic [7:0]        mem_addr_o;
  logic [3:0]        mem_wdata_o;
  logic [3:0]        acc_o;
  logic              carry_o;
  logic              zero_o;
  nad_pkg::nad_sfr_t sfr_o;
  int                num_errors  = 0;
  int                comparisons = 0;

  initial begin
    forever #25 clk_i = ~clk_i;
  end

  nad_datapath dut (.clk_i(clk_i), .srst_i(srst_i), .op_valid_i(op_valid_i), .op_i(op_i),
    .mem_rdata_i(mem_rdata), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
    .acc_o(acc_o), .carry_o(carry_o), .zero_o(zero_o), .sfr_o(sfr_o));

  nad_mem_model mdl (.clk_i(clk_i), .op_valid_i(op_valid_i), .op_i(op_i), .mem_we_i(mem_we_o),
    .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata));

  // ***************************************************************
  // Shared tasks
  // ***************************************************************
  task automatic complete_run;
    $display("num_errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One operation; window addresses get a decoy 8-bit address
  task automatic run(input nad_pkg::nad_op_e op, input logic [7:0] ad, input logic [3:0] m,
                     input logic [3:0] l, input logic [2:0] s);
    @(negedge clk_i);
    mdl.mem[ad]   = m;
    op_i.op       = op;
    op_i.mem_addr = (ad[7:5] == 3'h1) ? ~ad : ad;
    op_i.win_off  = ad[4:0];
    op_i.bit_sel  = s[1:0];
    op_i.sfr_sel  = s;
    op_i.literal  = l;
    op_valid_i    = 1'b1;
    @(negedge clk_i);
    op_valid_i    = 1'b0;
  endtask

  // State code: {2'b0, carry, zero, accumulator}
  task automatic tst(input logic [7:0] pre, input nad_pkg::nad_op_e op, input logic [7:0] ad,
                     input logic [11:0] x, input logic [7:0] exp);
    run(nad_pkg::OP_LITERAL_TO_ACCUMULATOR, 8'hF0, 4'h0, pre[5] ? 4'hF : 4'h0, 3'h0);
    run(nad_pkg::OP_ADD_LITERAL_CARRY, 8'hF0, 4'h0, {3'h0, pre[5]}, 3'h0);
    run(nad_pkg::OP_LOAD_ACCUMULATOR, 8'hFF, {3'h0, ~pre[4]}, 4'h0, 3'h0);
    run(nad_pkg::OP_LITERAL_TO_ACCUMULATOR, 8'hF0, 4'h0, pre[3:0], 3'h0);
    run(op, ad, x[11:8], x[7:4], x[2:0]);
    chk({10'h0, carry_o, zero_o, acc_o}, {8'h0, exp});
  endtask

  task automatic wr(input logic [7:0] ad, input logic [3:0] d);
    chk({3'h0, mem_we_o, mem_wdata_o, mem_addr_o}, {4'h1, d, ad});
  endtask

  // ***************************************************************
  // Scenarios
  // ***************************************************************
  task automatic t_arith;
    tst(8'h17, nad_pkg::OP_ADD_MEM_CARRY, 8'h45, 12'hA00, 8'h21);
    chk(16'(mem_we_o), 16'h0);
    tst(8'h2F, nad_pkg::OP_ADD_MEM_CARRY, 8'h46, 12'h000, 8'h30);
    tst(8'h3A, nad_pkg::OP_SUB_MEM_BORROW, 8'h47, 12'h200, 8'h38);
    tst(8'h22, nad_pkg::OP_SUB_MEM_BORROW, 8'h48, 12'h300, 8'h0F);
    tst(8'h3A, nad_pkg::OP_SUB_LITERAL_BORROW, 8'hF0, 12'h020, 8'h28);
    tst(8'h01, nad_pkg::OP_SUB_LITERAL_BORROW, 8'hF0, 12'h000, 8'h30);
    tst(8'h17, nad_pkg::OP_ADD_LITERAL_CARRY, 8'hF0, 12'h0A0, 8'h21);
    tst(8'h0F, nad_pkg::OP_INCREMENT_ACCUMULATOR, 8'hF0, 12'h000, 8'h30);
    tst(8'h30, nad_pkg::OP_DECREMENT_ACCUMULATOR, 8'hF0, 12'h000, 8'h0F);
    tst(8'h01, nad_pkg::OP_DECREMENT_ACCUMULATOR, 8'hF0, 12'h000, 8'h30);
    tst(8'h25, nad_pkg::OP_NOP, 8'h45, 12'hF00, 8'h25);
  endtask

  task automatic t_mem;
    tst(8'h05, nad_pkg::OP_INCREMENT_MEM, 8'h45, 12'hF00, 8'h35);
    wr(8'h45, 4'h0);
    tst(8'h05, nad_pkg::OP_DECREMENT_MEM, 8'h47, 12'h000, 8'h05);
    wr(8'h47, 4'hF);
    tst(8'h05, nad_pkg::OP_DECREMENT_MEM, 8'h48, 12'h100, 8'h35);
    wr(8'h48, 4'h0);
    tst(8'h20, nad_pkg::OP_ROTATE_MEM_RIGHT, 8'h49, 12'h300, 8'h20);
    wr(8'h49, 4'h9);
    tst(8'h10, nad_pkg::OP_ROTATE_MEM_RIGHT, 8'h4A, 12'h200, 8'h10);
    wr(8'h4A, 4'h1);
    tst(8'h00, nad_pkg::OP_ROTATE_MEM_LEFT, 8'h4B, 12'hE00, 8'h20);
    wr(8'h4B, 4'hC);
    tst(8'h20, nad_pkg::OP_ROTATE_MEM_LEFT, 8'h4C, 12'h000, 8'h00);
    wr(8'h4C, 4'h1);
    tst(8'h28, nad_pkg::OP_STORE_ACCUMULATOR, 8'h77, 12'h000, 8'h28);
    wr(8'h77, 4'h8);
    tst(8'h20, nad_pkg::OP_LOAD_ACCUMULATOR, 8'h12, 12'h000, 8'h30);
    tst(8'h30, nad_pkg::OP_LOAD_ACCUMULATOR, 8'h13, 12'h900, 8'h29);
  endtask

  task automatic t_logic;
    tst(8'h03, nad_pkg::OP_XOR_MEM, 8'h4D, 12'hB00, 8'h08);
    tst(8'h2B, nad_pkg::OP_XOR_MEM, 8'h4E, 12'hB00, 8'h30);
    tst(8'h37, nad_pkg::OP_AND_MEM, 8'h4F, 12'hA00, 8'h22);
    tst(8'h02, nad_pkg::OP_AND_MEM, 8'h50, 12'h500, 8'h10);
    tst(8'h13, nad_pkg::OP_OR_MEM, 8'h51, 12'hB00, 8'h1B);
    tst(8'h20, nad_pkg::OP_OR_MEM, 8'h52, 12'h000, 8'h20);
    tst(8'h03, nad_pkg::OP_AND_LITERAL, 8'hF0, 12'h040, 8'h10);
    tst(8'h13, nad_pkg::OP_OR_LITERAL, 8'hF0, 12'h0B0, 8'h1B);
    tst(8'h0B, nad_pkg::OP_XOR_LITERAL, 8'hF0, 12'h0B0, 8'h00);
    tst(8'h00, nad_pkg::OP_LITERAL_TO_ACCUMULATOR, 8'hF0, 12'h000, 8'h00);
    tst(8'h23, nad_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY, 8'hF0, 12'h000, 8'h29);
    tst(8'h01, nad_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY, 8'hF0, 12'h000, 8'h30);
    tst(8'h0E, nad_pkg::OP_ROTATE_LEFT_THROUGH_CARRY, 8'hF0, 12'h000, 8'h2C);
    tst(8'h08, nad_pkg::OP_ROTATE_LEFT_THROUGH_CARRY, 8'hF0, 12'h000, 8'h30);
    tst(8'h3E, nad_pkg::OP_ROTATE_ACCUMULATOR_RIGHT, 8'hF0, 12'h000, 8'h27);
    tst(8'h20, nad_pkg::OP_ROTATE_ACCUMULATOR_RIGHT, 8'hF0, 12'h000, 8'h30);
  endtask

  task automatic t_window;
    for (int b = 0; b < 4; b++) begin
      tst(8'h1A, nad_pkg::OP_BIT_CLEAR, 8'(32 + b), {8'hF0, 4'(b)}, 8'h1A);
      wr(8'(32 + b), 4'(4'hF ^ (4'h1 << b)));
      tst(8'h25, nad_pkg::OP_BIT_SET, 8'(60 + b), {8'h00, 4'(b)}, 8'h25);
      wr(8'(60 + b), 4'(4'h1 << b));
    end
    for (int i = 0; i < 8; i++) begin
      tst(8'h25, nad_pkg::OP_LITERAL_TO_FUNC_REG, 8'hF0, {4'h0, 4'(i ^ 5), 4'(i)}, 8'h25);
    end
    for (int i = 0; i < 8; i++) begin
      chk(16'(sfr_o[i]), 16'(i ^ 5));
    end
    tst(8'h25, nad_pkg::OP_FUNC_REG_TO_MEM, 8'h3F, 12'h002, 8'h25);
    wr(8'h3F, 4'h7);
    tst(8'h25, nad_pkg::OP_MEM_TO_FUNC_REG, 8'h21, 12'h906, 8'h25);
    chk(16'(sfr_o[6]), 16'h9);
    chk(16'(sfr_o[7]), 16'h2);
  endtask

  // Back-to-back issue: each operation sees the result of the one before
  task automatic t_burst;
    tst(8'h05, nad_pkg::OP_OR_LITERAL, 8'hF0, 12'h000, 8'h05);
    @(negedge clk_i);
    op_i.op      = nad_pkg::OP_LITERAL_TO_FUNC_REG;
    op_i.sfr_sel = 3'h3;
    op_i.literal = 4'hC;
    op_valid_i   = 1'b1;
    @(negedge clk_i);
    op_i.op      = nad_pkg::OP_FUNC_REG_TO_MEM;
    op_i.win_off = 5'h0A;
    @(negedge clk_i);
    wr(8'h2A, 4'hC);
    op_i.op      = nad_pkg::OP_OR_LITERAL;
    op_i.literal = 4'hA;
    @(negedge clk_i);
    op_i.op      = nad_pkg::OP_XOR_LITERAL;
    op_i.literal = 4'hF;
    @(negedge clk_i);
    op_valid_i   = 1'b0;
    chk({10'h0, carry_o, zero_o, acc_o}, 16'h0000);
    chk(16'(sfr_o[3]), 16'h000C);
  endtask

  // ***************************************************************
  // Main sequence and watchdog
  // ***************************************************************
  initial begin
    repeat (10) @(negedge clk_i);
    srst_i = 1'b0;
    t_arith();
    t_mem();
    t_logic();
    t_window();
    t_burst();
    complete_run();
  end

  initial begin
    #500000;
    num_errors++;
    complete_run();
  end
endmodule
